// ===== sfdp_parameter_read_bench.sv
`timescale 1ns/1ps
module sfdp_parameter_read_bench;
    import sfp_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [23:0] start_addr = 24'h000000;
    logic [8:0] num_bytes = 9'h001;
    logic tbl_we = 1'b0;
    logic [7:0] tbl_addr = 8'h00;
    logic [7:0] tbl_wdata = 8'h00;
    logic ready, rd_valid, done, busy, bad_opcode, busy_b, bad_b;
    logic [7:0] rd_data;
    logic [7:0] exp_tbl [256];
    logic [7:0] got [$];
    int stamp [$];
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic done_seen = 1'b0;
    logic bad_seen = 1'b0;
    logic oe_any = 1'b0;
    logic busy_seen = 1'b0;
    logic bad_main = 1'b0;

    sfp_if lk();
    sfp_if lk2();

    always #2 ref_clk = ~ref_clk;

    sfp_host i_sfp_host (.ref_clk(ref_clk), .reset(reset), .link(lk.host), .start(start),
        .start_addr(start_addr), .num_bytes(num_bytes), .ready(ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done));
    sfp_dev i_sfp_dev (.ref_clk(ref_clk), .reset(reset), .link(lk.dev), .tbl_we(tbl_we),
        .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .busy(busy), .bad_opcode(bad_opcode));
    // Second device, driven bit by bit for fault cases
    sfp_dev i_sfp_dev_b (.ref_clk(ref_clk), .reset(reset), .link(lk2.dev), .tbl_we(tbl_we),
        .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .busy(busy_b), .bad_opcode(bad_b));
    sfp_link_assertions i_sfp_link_assertions (.ref_clk(ref_clk), .reset(reset),
        .cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si), .so_o(lk.so_o), .so_oe(lk.so_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Byte capture, pulse flags and hang limit
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (rd_valid === 1'b1)
        begin
            got.push_back(rd_data);
            stamp.push_back(cyc);
        end
        if (done === 1'b1)
            done_seen = 1'b1;
        if (bad_b === 1'b1)
            bad_seen = 1'b1;
        if (busy === 1'b1)
            busy_seen = 1'b1;
        if (bad_opcode === 1'b1)
            bad_main = 1'b1;
        if (cyc == 40000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic load_table();
        for (int i = 0; i < 256; i++)
        begin
            exp_tbl[i] = 8'(i * 8'h3B + 8'h11);
            tbl_we = 1'b1;
            tbl_addr = 8'(i);
            tbl_wdata = exp_tbl[i];
            @(negedge ref_clk);
        end
        tbl_we = 1'b0;
    endtask

    // Host read; bytes follow the table with fixed spacing
    task automatic do_read(input logic [23:0] a, input logic [8:0] n);
        got.delete();
        stamp.delete();
        done_seen = 1'b0;
        busy_seen = 1'b0;
        for (int k = 0; k < 50 && ready !== 1'b1; k++)
            @(negedge ref_clk);
        check(ready, 1'b1);
        start = 1'b1;
        start_addr = a;
        num_bytes = n;
        @(negedge ref_clk);
        start = 1'b0;
        for (int k = 0; k < 30000 && !done_seen; k++)
            @(negedge ref_clk);
        check(done_seen, 1'b1);
        check(got.size(), n);
        for (int k = 0; k < got.size(); k++)
            check(got[k], exp_tbl[8'(a[7:0] + k)]);
        for (int k = 1; k < stamp.size(); k++)
            check(stamp[k] - stamp[k-1], 96);
        repeat (4) @(negedge ref_clk);
        check(lk.so_oe, 1'b0);
        check(busy_seen, 1'b1);
        check(busy, 1'b0);
        check(bad_main, 1'b0);
    endtask

    task automatic bb_bits(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 0; i < nb; i++)
        begin
            lk2.si = tx[7 - i];
            repeat (6) @(negedge ref_clk);
            rx = {rx[6:0], lk2.so_o};
            oe_any = oe_any | lk2.so_oe;
            lk2.sck = 1'b1;
            repeat (6) @(negedge ref_clk);
            lk2.sck = 1'b0;
        end
    endtask

    task automatic bb_open(input logic [7:0] opc, input logic [23:0] a);
        logic [7:0] rx;
        oe_any = 1'b0;
        bad_seen = 1'b0;
        lk2.cs_n = 1'b0;
        bb_bits(opc, 8, rx);
        bb_bits(a[23:16], 8, rx);
        bb_bits(a[15:8], 8, rx);
        bb_bits(a[7:0], 8, rx);
        bb_bits(8'hC3, 8, rx);
    endtask

    task automatic bb_close();
        repeat (6) @(negedge ref_clk);
        lk2.cs_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        check(lk2.so_oe, 1'b0);
    endtask

    task automatic t_bad_opcode();
        logic [7:0] rx;
        bb_open(8'hA5, 24'h000010);
        bb_bits(8'hFF, 8, rx);
        bb_close();
        check(bad_seen, 1'b1);
        check(oe_any, 1'b0);
    endtask

    task automatic t_mid_byte_abort();
        logic [7:0] rx;
        bb_open(SFP_OPC_READ, 24'h7F0042);
        check(oe_any, 1'b0);
        bb_bits(8'h00, 8, rx);
        check(rx, exp_tbl[8'h42]);
        bb_bits(8'h00, 3, rx);
        bb_close();
        check(busy_b, 1'b0);
        bb_open(SFP_OPC_READ, 24'h000007);
        bb_bits(8'h00, 8, rx);
        check(rx, exp_tbl[8'h07]);
        bb_close();
    endtask

    task automatic t_offset_read();
        do_read(24'hC35A10, 9'h004);
    endtask

    task automatic t_wrap_read();
        do_read(24'h0000FD, 9'h005);
    endtask

    task automatic t_single_byte();
        do_read(24'h0000FF, 9'h001);
    endtask

    task automatic t_full_table();
        do_read(24'h000000, 9'h100);
    endtask

    // Main sequence
    initial
    begin
        lk2.cs_n = 1'b1;
        lk2.sck = 1'b0;
        lk2.si = 1'b0;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        load_table();
        t_offset_read();
        t_wrap_read();
        t_single_byte();
        t_bad_opcode();
        t_mid_byte_abort();
        t_full_table();
        tally_and_finish();
    end
endmodule

// ===== sfp_dev.sv
// Overview of operation
// (RULE1) Device holds 256-byte table, read sequentially
// (RULE2) Header in on SI, data out on SO
// (RULE3) Opcode 5Ah, eight clocks, MSB first
// (RULE4) 24-bit address follows, A[23] first
// (RULE5) Host clocks one dummy byte after address
// (RULE6) Each byte driven over eight clocks, MSB first
// (RULE7) Bytes continue from incrementing addresses while selected
// (RULE8) Deselect ends read, output goes high-impedance
// (RULE9) Deselect accepted anywhere, even mid-byte
// (RULE10) Address FFh wraps to 00h without gap
// (RULE11) Low eight address bits index; rest ignored
`timescale 1ns/1ps
module sfp_dev
    import sfp_pkg::*;
#(
    parameter int DEPTH = SFP_TABLE_DEPTH
)
(
    input wire logic ref_clk,
    input wire logic reset,
    sfp_if.dev link,
    input wire logic tbl_we,
    input wire logic [SFP_IDX_BITS-1:0] tbl_addr,
    input wire logic [7:0] tbl_wdata,
    output logic busy,
    output logic bad_opcode
);

    // Parameter table storage
    logic [7:0] table_mem [0:DEPTH-1];

    // Pin synchronisers
    logic cs_n_s1_r;
    logic cs_n_s2_r;
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_d_r;
    logic si_s1_r;
    logic si_s2_r;

    // Sequencer
    sfp_dev_e state_r;
    logic [4:0] cnt_r;
    logic [SFP_ADDR_BITS-1:0] addr_sh_r;
    logic [7:0] cmd_sh_r;
    logic [SFP_IDX_BITS-1:0] idx_r;
    logic [7:0] out_sh_r;
    logic so_r;
    logic so_oe_r;
    logic bad_r;

    logic sck_rise;
    logic sck_fall;
    logic selected;

    // Table loading from the user side
    always_ff @(posedge ref_clk)
    begin
        if (tbl_we)
        begin
            table_mem[tbl_addr] <= tbl_wdata; // see (RULE1)
        end
    end

    // Two-stage capture of the link pins
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cs_n_s1_r <= 1'b1;
            cs_n_s2_r <= 1'b1;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r <= 1'b0;
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
        end
        else
        begin
            cs_n_s1_r <= link.cs_n;
            cs_n_s2_r <= cs_n_s1_r;
            sck_s1_r <= link.sck;
            sck_s2_r <= sck_s1_r;
            sck_d_r <= sck_s2_r;
            si_s1_r <= link.si;
            si_s2_r <= si_s1_r;
        end
    end

    // Edge detection on the synchronised clock
    assign selected = ~cs_n_s2_r;
    assign sck_rise = selected & sck_s2_r & ~sck_d_r;
    assign sck_fall = selected & ~sck_s2_r & sck_d_r;

    // Phase sequencing, sampled on rising edges
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= SFP_DV_IDLE;
        end
        else if (!selected)
        begin
            state_r <= SFP_DV_IDLE; // see (RULE8) see (RULE9)
        end
        else if (sck_rise)
        begin
            case (state_r)
                SFP_DV_IDLE:
                begin
                    state_r <= SFP_DV_CMD;
                end
                SFP_DV_CMD:
                begin
                    if (cnt_r == 5'(SFP_CMD_BITS - 1))
                    begin
                        if ({cmd_sh_r[6:0], si_s2_r} == SFP_OPC_READ)
                        begin
                            state_r <= SFP_DV_ADDR; // see (RULE3)
                        end
                        else
                        begin
                            state_r <= SFP_DV_SKIP;
                        end
                    end
                end
                SFP_DV_ADDR:
                begin
                    if (cnt_r == 5'(SFP_ADDR_BITS - 1))
                    begin
                        state_r <= SFP_DV_DUMMY; // see (RULE4)
                    end
                end
                SFP_DV_DUMMY:
                begin
                    if (cnt_r == 5'(SFP_DUMMY_BITS - 1))
                    begin
                        state_r <= SFP_DV_DATA; // see (RULE5)
                    end
                end
                SFP_DV_DATA:
                begin
                    state_r <= SFP_DV_DATA;
                end
                SFP_DV_SKIP:
                begin
                    state_r <= SFP_DV_SKIP;
                end
                default:
                begin
                    state_r <= SFP_DV_IDLE;
                end
            endcase
        end
    end

    // Bit counter per phase
    always_ff @(posedge ref_clk)
    begin
        if (reset || !selected)
        begin
            cnt_r <= 5'h00;
        end
        else if (sck_rise && state_r != SFP_DV_DATA)
        begin
            if (state_r == SFP_DV_IDLE)
            begin
                cnt_r <= 5'h01;
            end
            else if ((state_r == SFP_DV_CMD && cnt_r == 5'(SFP_CMD_BITS - 1))
                || (state_r == SFP_DV_ADDR && cnt_r == 5'(SFP_ADDR_BITS - 1))
                || (state_r == SFP_DV_DUMMY && cnt_r == 5'(SFP_DUMMY_BITS - 1)))
            begin
                cnt_r <= 5'h00;
            end
            else
            begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
        else if (sck_fall && state_r == SFP_DV_DATA)
        begin
            cnt_r <= {2'b00, cnt_r[2:0] + 3'h1};
        end
    end

    // Serial input shifting on the single data line
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cmd_sh_r <= 8'h00;
            addr_sh_r <= '0;
        end
        else if (sck_rise)
        begin
            if (state_r == SFP_DV_IDLE || state_r == SFP_DV_CMD)
            begin
                cmd_sh_r <= {cmd_sh_r[6:0], si_s2_r}; // see (RULE2) see (RULE3)
            end
            if (state_r == SFP_DV_ADDR)
            begin
                addr_sh_r <= {addr_sh_r[SFP_ADDR_BITS-2:0], si_s2_r}; // see (RULE4)
            end
        end
    end

    // Table index: low address bits, dummy value ignored
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            idx_r <= '0;
        end
        else if (sck_rise && state_r == SFP_DV_DUMMY && cnt_r == 5'h00)
        begin
            idx_r <= addr_sh_r[SFP_IDX_BITS-1:0]; // see (RULE11)
        end
        else if (sck_fall && state_r == SFP_DV_DATA && cnt_r[2:0] == 3'h0)
        begin
            idx_r <= idx_r + 1'b1; // see (RULE7) see (RULE10)
        end
    end

    // Output shifting on falling edges, MSB first
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            out_sh_r <= 8'h00;
            so_r <= 1'b0;
        end
        else if (sck_fall && state_r == SFP_DV_DATA)
        begin
            if (cnt_r[2:0] == 3'h0)
            begin
                so_r <= table_mem[idx_r][7]; // see (RULE6)
                out_sh_r <= {table_mem[idx_r][6:0], 1'b0};
            end
            else
            begin
                so_r <= out_sh_r[7]; // see (RULE6)
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    // Output enable: on from first data bit, off at deselect
    always_ff @(posedge ref_clk)
    begin
        if (reset || !selected)
        begin
            so_oe_r <= 1'b0; // see (RULE8) see (RULE9)
        end
        else if (sck_fall && state_r == SFP_DV_DATA)
        begin
            so_oe_r <= 1'b1; // see (RULE2)
        end
    end

    // Unknown opcode flag, one pulse
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            bad_r <= 1'b0;
        end
        else
        begin
            bad_r <= selected && sck_rise && state_r == SFP_DV_CMD
                && cnt_r == 5'(SFP_CMD_BITS - 1)
                && {cmd_sh_r[6:0], si_s2_r} != SFP_OPC_READ;
        end
    end

    // Link and user outputs
    assign link.so_o = so_r;
    assign link.so_oe = so_oe_r;
    assign busy = (state_r == SFP_DV_DATA);
    assign bad_opcode = bad_r;

endmodule

// ===== sfp_host.sv
`timescale 1ns/1ps
module sfp_host
    import sfp_pkg::*;
#(
    parameter int HALF_CYC = SFP_SCK_HALF_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset,
    sfp_if.host link,
    input wire logic start,
    input wire logic [SFP_ADDR_BITS-1:0] start_addr,
    input wire logic [8:0] num_bytes,
    output logic ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done
);

    sfp_host_e state_r;
    logic [7:0] div_r;
    logic tick;
    logic cs_n_r;
    logic sck_r;
    logic si_r;
    logic [SFP_HDR_BITS-1:0] tx_sh_r;
    logic [12:0] rise_cnt_r;
    logic [12:0] last_rise_r;
    logic [7:0] rx_sh_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic done_r;
    logic so_s1_r;
    logic so_s2_r;
    logic sample;

    // Half-period enable for the link clock
    assign tick = (div_r == 8'(HALF_CYC - 1));
    always_ff @(posedge ref_clk)
    begin
        if (reset || state_r == SFP_HS_IDLE || tick)
        begin
            div_r <= 8'h00;
        end
        else
        begin
            div_r <= div_r + 8'h01;
        end
    end

    // Device output capture, released line reads high
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            so_s1_r <= 1'b1;
            so_s2_r <= 1'b1;
        end
        else
        begin
            so_s1_r <= link.so_oe ? link.so_o : 1'b1;
            so_s2_r <= so_s1_r;
        end
    end

    // Frame sequencing and pin drive
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= SFP_HS_IDLE;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
            si_r <= 1'b0;
            tx_sh_r <= '0;
            rise_cnt_r <= 13'h0000;
            last_rise_r <= 13'h0000;
        end
        else
        begin
            case (state_r)
                SFP_HS_IDLE:
                begin
                    if (start && num_bytes != 9'h000)
                    begin
                        state_r <= SFP_HS_SETUP;
                        cs_n_r <= 1'b0;
                        si_r <= SFP_OPC_READ[7];
                        tx_sh_r <= {SFP_OPC_READ[6:0], start_addr, SFP_DUMMY_VAL, 1'b0};
                        rise_cnt_r <= 13'h0000;
                        last_rise_r <= 13'(SFP_HDR_BITS - 1) + {num_bytes, 3'b000};
                    end
                end
                SFP_HS_SETUP:
                begin
                    if (tick)
                    begin
                        state_r <= SFP_HS_SHIFT;
                        sck_r <= 1'b1;
                    end
                end
                SFP_HS_SHIFT:
                begin
                    if (tick && sck_r)
                    begin
                        sck_r <= 1'b0;
                        si_r <= tx_sh_r[SFP_HDR_BITS-1];
                        tx_sh_r <= {tx_sh_r[SFP_HDR_BITS-2:0], 1'b0};
                        if (rise_cnt_r == last_rise_r)
                        begin
                            state_r <= SFP_HS_END;
                        end
                        rise_cnt_r <= rise_cnt_r + 13'h0001;
                    end
                    else if (tick)
                    begin
                        sck_r <= 1'b1;
                    end
                end
                SFP_HS_END:
                begin
                    if (tick)
                    begin
                        state_r <= SFP_HS_IDLE;
                        cs_n_r <= 1'b1;
                        si_r <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= SFP_HS_IDLE;
                end
            endcase
        end
    end

    // Data capture at each rising edge past the header
    assign sample = (state_r == SFP_HS_SETUP || state_r == SFP_HS_SHIFT) && tick
        && !sck_r && rise_cnt_r >= 13'(SFP_HDR_BITS);
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_sh_r <= 8'h00;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= 1'b0;
            if (sample && state_r == SFP_HS_SHIFT)
            begin
                rx_sh_r <= {rx_sh_r[6:0], so_s2_r};
                if (rise_cnt_r[2:0] == 3'h7)
                begin
                    rd_data_r <= {rx_sh_r[6:0], so_s2_r};
                    rd_valid_r <= 1'b1;
                end
            end
        end
    end

    // Completion pulse
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= (state_r == SFP_HS_END) && tick;
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.si = si_r;
    assign ready = (state_r == SFP_HS_IDLE);
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign done = done_r;

endmodule

// ===== sfp_if.sv
`timescale 1ns/1ps
// Single-lane serial link between host and table device
interface sfp_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_o;
    logic so_oe;

    modport dev
    (
        input cs_n,
        input sck,
        input si,
        output so_o,
        output so_oe
    );

    modport host
    (
        output cs_n,
        output sck,
        output si,
        input so_o,
        input so_oe
    );
endinterface

// ===== sfp_link_assertions.sv
`timescale 1ns/1ps
module sfp_link_assertions
    import sfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe
);
    logic [11:0] rise_cnt_r;

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Link clock rises seen in this frame
    always_ff @(posedge ref_clk)
    begin
        if (reset || $fell(cs_n))
            rise_cnt_r <= 12'h000;
        else if ($rose(sck) && !cs_n)
            rise_cnt_r <= rise_cnt_r + 12'h001;
    end

    // Clock stays low after select, then a full high phase
    sequence cs_setup_s;
        !sck [*5];
    endsequence
    sequence sck_high_s;
        sck [*6] ##1 !sck;
    endsequence

    oe_release_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("output enable high while deselected");
    idle_clock_a: assert property (cs_n |-> !sck)
        else $error("link clock high outside a frame");
    select_setup_a: assert property ($fell(cs_n) |-> cs_setup_s)
        else $error("link clock rose too soon after select");
    clock_width_a: assert property ($rose(sck) |-> sck_high_s)
        else $error("link clock high phase has wrong length");
    opcode_order_a: assert property ($rose(sck) && !cs_n && rise_cnt_r < 12'h008 |->
        si == SFP_OPC_READ[3'h7 - rise_cnt_r[2:0]])
        else $error("opcode bit wrong on serial input");
    dummy_byte_a: assert property ($rose(sck) && rise_cnt_r >= 12'h020 &&
        rise_cnt_r < 12'h028 |-> si == SFP_DUMMY_VAL[3'h7 - rise_cnt_r[2:0]])
        else $error("dummy bit wrong on serial input");
    data_start_a: assert property ($rose(so_oe) |-> rise_cnt_r == 12'h028 && !sck)
        else $error("output enabled before header complete");
    out_hold_a: assert property (sck && $past(sck) && so_oe |-> $stable(so_o))
        else $error("serial output changed while clock high");
endmodule

// ===== sfp_pkg.sv
package sfp_pkg;
    // Command and framing
    localparam logic [7:0] SFP_OPC_READ = 8'h5A;
    localparam int SFP_CMD_BITS = 8;
    localparam int SFP_ADDR_BITS = 24;
    localparam int SFP_DUMMY_BITS = 8;
    localparam int SFP_BYTE_BITS = 8;
    localparam int SFP_HDR_BITS = SFP_CMD_BITS + SFP_ADDR_BITS + SFP_DUMMY_BITS;
    // Table geometry
    localparam int SFP_TABLE_DEPTH = 256;
    localparam int SFP_IDX_BITS = $clog2(SFP_TABLE_DEPTH);
    localparam logic [7:0] SFP_DUMMY_VAL = 8'h00;
    // Link clock timing
    localparam int SFP_REF_PERIOD_NS = 4;
    localparam int SFP_SCK_PERIOD_NS = 48;
    localparam int SFP_SCK_HALF_CYC = SFP_SCK_PERIOD_NS / (2 * SFP_REF_PERIOD_NS);

    // Device sequencer states
    typedef enum logic [2:0]
    {
        SFP_DV_IDLE = 3'b000,
        SFP_DV_CMD = 3'b001,
        SFP_DV_ADDR = 3'b010,
        SFP_DV_DUMMY = 3'b011,
        SFP_DV_DATA = 3'b100,
        SFP_DV_SKIP = 3'b101
    } sfp_dev_e;

    // Host sequencer states
    typedef enum logic [1:0]
    {
        SFP_HS_IDLE = 2'b00,
        SFP_HS_SETUP = 2'b01,
        SFP_HS_SHIFT = 2'b10,
        SFP_HS_END = 2'b11
    } sfp_host_e;
endpackage
